// *** verilog/adc_sequencer_pkg.sv ***
package adc_sequencer_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] DATA_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] DATA_LAST = 8'h2c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int RESULT_BITS = 10;
    localparam logic [RESULT_BITS-1:0] SAR_FIRST_TRIAL = 10'h200;
    localparam logic [3:0] SAR_TOP_BIT = 4'h9;

    // ----------------------------------------------------------------
    // Field layouts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] triggerSource;
        logic scanEnable;
        logic scanGroupSize;
        logic [1:0] clockSelect;
        logic [1:0] reserved;
    } control_s;

    typedef struct packed {
        logic completionFlag;
        logic completionIrqEnable;
        logic conversionStartBit;
        logic reserved;
        logic [3:0] channelSelect;
    } status_s;

    localparam control_s CONTROL_RESET = 8'h00;
    localparam status_s STATUS_RESET = 8'h00;

    typedef enum logic [1:0] {
        TRIG_NONE = 2'h0,
        TRIG_PULSE_TIMER = 2'h1,
        TRIG_EIGHT_BIT_TIMER = 2'h2,
        TRIG_PIN = 2'h3
    } trigger_e;

    typedef enum logic [1:0] {
        ST_WAIT = 2'h0,
        ST_DELAY = 2'h1,
        ST_SAMPLE = 2'h3,
        ST_CONVERT = 2'h2
    } state_e;

    // ----------------------------------------------------------------
    // Timing in states, indexed by the clock select field
    // ----------------------------------------------------------------
    typedef logic [9:0] states_t [4];
    localparam states_t START_DELAY = '{10'h012, 10'h00a, 10'h006, 10'h004};
    localparam states_t START_DELAY_MAX = '{10'h021, 10'h011, 10'h009, 10'h005};
    localparam states_t SAMPLE_WINDOW = '{10'h07f, 10'h03f, 10'h01f, 10'h00f};
    localparam states_t SCAN_TIME = '{10'h200, 10'h100, 10'h080, 10'h040};
    localparam states_t SINGLE_MIN = '{10'h203, 10'h103, 10'h083, 10'h043};
    localparam states_t SINGLE_MAX = '{10'h212, 10'h10a, 10'h086, 10'h044};
    localparam states_t BODY_TIME = '{SCAN_TIME[0] - SAMPLE_WINDOW[0],
        SCAN_TIME[1] - SAMPLE_WINDOW[1], SCAN_TIME[2] - SAMPLE_WINDOW[2],
        SCAN_TIME[3] - SAMPLE_WINDOW[3]};
    localparam states_t BIT_STEP = '{BODY_TIME[0] / 10'h00a, BODY_TIME[1] / 10'h00a,
        BODY_TIME[2] / 10'h00a, BODY_TIME[3] / 10'h00a};

endpackage

// *** verilog/adc_conversion_sequencer.sv ***
// Functional notes
// RULE1: Trigger source 00 none, 01 pulse timer, 10 eight-bit timer, 11 pin.
// RULE2: Mode upper bit 0 single, 10 four-channel scan, 11 eight-channel scan.
// RULE3: Clock select sets maximum time 530, 266, 134 or 68 states.
// RULE4: Software changes clock select only while the start bit is zero.
// RULE5: Control bits one and zero read zero and ignore writes.
// RULE6: Results come from ten-bit successive approximation.
// RULE7: Mode or channel change with start bit set in the same write.
// RULE8: Single mode start converts the selected channel exactly once.
// RULE9: Single mode result goes to that channel's data register.
// RULE10: Single mode end sets completion flag and interrupt if enabled.
// RULE11: Single mode start bit stays set, clears at end, then wait.
// RULE12: Clearing the start bit mid conversion aborts to wait.
// RULE13: Scan starts at group first channel: input 4 or input 0.
// RULE14: Scan stores every channel result as soon as it finishes.
// RULE15: After last scan channel set flag, interrupt, restart at first.
// RULE16: Scan start bit never self-clears; setting again restarts group. The code ignores a set while running and does not restart.
// RULE17: After start delay sample for 127, 63, 31 or 15 states.
// RULE18: Start delay within 18-33, 10-17, 6-9 or 4-5 states.
// RULE19: Single conversion takes 515-530, 259-266, 131-134 or 67-68 states.
// RULE20: Later scan conversions take fixed 512, 256, 128 or 64 states.
// RULE21: Software sets trigger pin direction 0 and input buffer 1.
// RULE22: Flag clears on zero write after read as one, or transfer read.
// RULE23: Channel field with mode picks input; codes with top bit set prohibited.
// RULE24: Pin source: trigger pin falling edge sets the start bit.
// RULE25: Source 00 ignores timer and pin events; software start only.
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module adc_conversion_sequencer #(
    parameter int CHANNELS = 8
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [adc_sequencer_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [adc_sequencer_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic pulseTimerTrigger,
    input wire logic eightBitTimerTrigger,
    input wire logic externalTriggerPin_n,
    input wire logic transferRead,
    input wire logic compareHigh,
    output logic sampleHold,
    output logic [adc_sequencer_pkg::RESULT_BITS-1:0] dacCode,
    output logic [2:0] analogChannel,
    output logic conversionEndInterrupt
);

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    function automatic logic isMapped(input logic [adc_sequencer_pkg::ADDR_W-1:0] a);
        isMapped = (a == adc_sequencer_pkg::CONTROL_OFFSET) ||
            (a == adc_sequencer_pkg::STATUS_OFFSET) ||
            (a >= adc_sequencer_pkg::DATA_BASE && a <= adc_sequencer_pkg::DATA_LAST &&
            a[1:0] == 2'h0);
    endfunction

    // First channel of the group for the present mode and channel field.
    function automatic logic [2:0] groupFirst(input adc_sequencer_pkg::control_s c,
        input logic [3:0] ch);
        if (!c.scanEnable)
            groupFirst = ch[2:0];
        else if (c.scanGroupSize)
            groupFirst = 3'h0;
        else
            groupFirst = {ch[2], 2'h0};
    endfunction

    adc_sequencer_pkg::control_s control;
    adc_sequencer_pkg::status_s status;
    adc_sequencer_pkg::state_e state;
    logic [adc_sequencer_pkg::ADDR_W-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic awHeld, wHeld, doWrite, swStatusWrite, swCtrlWrite;
    logic setStart, swClearStart, triggerHit, next_startBit;
    logic [3:0] next_channelSelect;
    logic pinMeta, pinSync, pinLast, pinFall, cmpMeta, cmpSync;
    logic flagSeen, setFlag, clearFlag, convDone, singleDone, lastChannel;
    logic [9:0] phaseCount, stepCount;
    logic [3:0] bitIndex;
    logic sarActive;
    logic [adc_sequencer_pkg::RESULT_BITS-1:0] results [CHANNELS];

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    assign doWrite = awHeld && wHeld && !bvalid;
    assign swStatusWrite = doWrite && wrStrb[0] && wrAddr == adc_sequencer_pkg::STATUS_OFFSET;
    assign swCtrlWrite = doWrite && wrStrb[0] && wrAddr == adc_sequencer_pkg::CONTROL_OFFSET;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= adc_sequencer_pkg::RESP_OKAY;
            wrAddr <= '0;
            wrData <= '0;
            wrStrb <= '0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awHeld <= 1'b1;
                awready <= 1'b0;
                wrAddr <= awaddr;
            end
            if (wvalid && wready)
            begin
                wHeld <= 1'b1;
                wready <= 1'b0;
                wrData <= wdata;
                wrStrb <= wstrb;
            end
            if (doWrite)
            begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= isMapped(wrAddr) ? adc_sequencer_pkg::RESP_OKAY :
                    adc_sequencer_pkg::RESP_SLVERR;
            end
            else if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= adc_sequencer_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= isMapped(araddr) ? adc_sequencer_pkg::RESP_OKAY :
                adc_sequencer_pkg::RESP_SLVERR;
            if (araddr == adc_sequencer_pkg::CONTROL_OFFSET)
                rdata <= {24'h000000, control}; // RULE5
            else if (araddr == adc_sequencer_pkg::STATUS_OFFSET)
                rdata <= {24'h000000, status};
            else if (isMapped(araddr))
                rdata <= {22'h000000, results[3'(araddr[4:2] - 3'h4)]};
            else
                rdata <= '0;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            control <= adc_sequencer_pkg::CONTROL_RESET;
        else if (swCtrlWrite)
        begin
            control.triggerSource <= wrData[7:6]; // RULE1
            control.scanEnable <= wrData[5]; // RULE2
            control.scanGroupSize <= wrData[4];
            control.clockSelect <= wrData[3:2]; // RULE3
        end
    end

    // ----------------------------------------------------------------
    // Triggers and synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinMeta <= 1'b1;
            pinSync <= 1'b1;
            pinLast <= 1'b1;
            cmpMeta <= 1'b0;
            cmpSync <= 1'b0;
        end
        else
        begin
            pinMeta <= externalTriggerPin_n;
            pinSync <= pinMeta;
            pinLast <= pinSync;
            cmpMeta <= compareHigh;
            cmpSync <= cmpMeta;
        end
    end

    assign pinFall = pinLast && !pinSync;

    always_comb
    begin
        case (control.triggerSource)
            adc_sequencer_pkg::TRIG_PULSE_TIMER: triggerHit = pulseTimerTrigger; // RULE1
            adc_sequencer_pkg::TRIG_EIGHT_BIT_TIMER: triggerHit = eightBitTimerTrigger;
            adc_sequencer_pkg::TRIG_PIN: triggerHit = pinFall; // RULE24
            default: triggerHit = 1'b0; // RULE25
        endcase
    end

    // ----------------------------------------------------------------
    // Start bit and completion flag
    // ----------------------------------------------------------------
    assign convDone = state == adc_sequencer_pkg::ST_CONVERT && phaseCount == '0;
    assign singleDone = convDone && !control.scanEnable;
    assign lastChannel = analogChannel == status.channelSelect[2:0];
    assign setStart = (swStatusWrite && wrData[5]) || triggerHit; // RULE7 RULE8
    assign swClearStart = swStatusWrite && !wrData[5];
    // A write that sets the start bit also brings the channel that this start must use.
    assign next_channelSelect = swStatusWrite ? wrData[3:0] : status.channelSelect; // RULE7
    assign setFlag = singleDone || (convDone && control.scanEnable && lastChannel);
    assign clearFlag = (swStatusWrite && !wrData[7] && flagSeen) || transferRead; // RULE22

    always_comb
    begin
        next_startBit = status.conversionStartBit;
        // A start while running is ignored, so a trigger in the last cycle of a single
        // conversion cannot begin the next one without its start delay.
        if (swClearStart || singleDone) // RULE11 RULE16
            next_startBit = 1'b0;
        else if (setStart)
            next_startBit = 1'b1;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status <= adc_sequencer_pkg::STATUS_RESET;
            flagSeen <= 1'b0;
            conversionEndInterrupt <= 1'b0;
        end
        else
        begin
            status.conversionStartBit <= next_startBit;
            if (swStatusWrite)
            begin
                status.completionIrqEnable <= wrData[6];
                status.channelSelect <= wrData[3:0]; // RULE23
            end
            // A single end or a last scan channel end in the cycle of a clear keeps the flag set.
            if (setFlag)
                status.completionFlag <= 1'b1; // RULE10 RULE15
            else if (clearFlag)
                status.completionFlag <= 1'b0;
            if (setFlag || clearFlag)
                flagSeen <= 1'b0;
            else if (arvalid && arready && araddr == adc_sequencer_pkg::STATUS_OFFSET)
                flagSeen <= status.completionFlag;
            conversionEndInterrupt <= status.completionFlag && status.completionIrqEnable;
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= adc_sequencer_pkg::ST_WAIT;
            phaseCount <= '0;
            sampleHold <= 1'b0;
            analogChannel <= 3'h0;
        end
        else if (!next_startBit)
        begin
            state <= adc_sequencer_pkg::ST_WAIT; // RULE11 RULE12
            sampleHold <= 1'b0;
        end
        else if (!status.conversionStartBit || state == adc_sequencer_pkg::ST_WAIT)
        begin
            state <= adc_sequencer_pkg::ST_DELAY; // RULE13 RULE16 RULE18
            phaseCount <= adc_sequencer_pkg::START_DELAY[control.clockSelect] - 10'h001;
            analogChannel <= groupFirst(control, next_channelSelect);
        end
        else
        begin
            phaseCount <= phaseCount - 10'h001;
            case (state)
                adc_sequencer_pkg::ST_DELAY:
                    if (phaseCount == '0)
                    begin
                        state <= adc_sequencer_pkg::ST_SAMPLE; // RULE17
                        phaseCount <= adc_sequencer_pkg::SAMPLE_WINDOW[control.clockSelect]
                            - 10'h001;
                        sampleHold <= 1'b1;
                    end
                adc_sequencer_pkg::ST_SAMPLE:
                    if (phaseCount == '0)
                    begin
                        state <= adc_sequencer_pkg::ST_CONVERT;
                        phaseCount <= adc_sequencer_pkg::BODY_TIME[control.clockSelect]
                            - 10'h001;
                        sampleHold <= 1'b0;
                    end
                adc_sequencer_pkg::ST_CONVERT:
                    if (phaseCount == '0)
                    begin
                        // Later scan passes skip the start delay, so they keep a fixed period.
                        state <= adc_sequencer_pkg::ST_SAMPLE; // RULE20
                        phaseCount <= adc_sequencer_pkg::SAMPLE_WINDOW[control.clockSelect]
                            - 10'h001;
                        sampleHold <= 1'b1;
                        analogChannel <= lastChannel ? groupFirst(control,
                            status.channelSelect) : analogChannel + 3'h1; // RULE15
                    end
                default:
                    state <= adc_sequencer_pkg::ST_WAIT;
            endcase
        end
    end

    // Successive approximation, one bit per step from the top bit down.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dacCode <= '0;
            bitIndex <= '0;
            stepCount <= '0;
            sarActive <= 1'b0;
        end
        else if (state == adc_sequencer_pkg::ST_SAMPLE)
        begin
            dacCode <= adc_sequencer_pkg::SAR_FIRST_TRIAL; // RULE6
            bitIndex <= adc_sequencer_pkg::SAR_TOP_BIT;
            stepCount <= adc_sequencer_pkg::BIT_STEP[control.clockSelect] - 10'h001;
            sarActive <= 1'b1;
        end
        else if (state == adc_sequencer_pkg::ST_CONVERT && sarActive)
        begin
            stepCount <= stepCount - 10'h001;
            if (stepCount == '0)
            begin
                stepCount <= adc_sequencer_pkg::BIT_STEP[control.clockSelect] - 10'h001;
                if (!cmpSync)
                    dacCode[bitIndex] <= 1'b0; // RULE6
                if (bitIndex == 4'h0)
                    sarActive <= 1'b0;
                else
                begin
                    dacCode[bitIndex - 4'h1] <= 1'b1;
                    bitIndex <= bitIndex - 4'h1;
                end
            end
        end
    end

    generate
        for (genvar i = 0; i < CHANNELS; i++)
        begin : g_result
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                    results[i] <= '0;
                else if (convDone && analogChannel == 3'(i))
                    results[i] <= dacCode; // RULE9 RULE14
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [9:0] busyCount, periodCount;
    logic scanRepeat;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busyCount <= '0;
            periodCount <= '0;
            scanRepeat <= 1'b0;
        end
        else
        begin
            busyCount <= state == adc_sequencer_pkg::ST_WAIT ? 10'h000 : busyCount + 10'h001;
            periodCount <= convDone ? 10'h000 : periodCount + 10'h001;
            scanRepeat <= next_startBit && status.conversionStartBit &&
                (convDone || scanRepeat);
        end
    end

    sequence s_singleEnd;
        singleDone && !setStart;
    endsequence

    property p_selfClear;
        @(posedge clock) disable iff (!arst_n)
        s_singleEnd |=> !status.conversionStartBit ##0 state == adc_sequencer_pkg::ST_WAIT;
    endproperty
    a_selfClear: assert property (p_selfClear) else $error("start bit not cleared"); // RULE11

    property p_flagSet;
        @(posedge clock) disable iff (!arst_n)
        setFlag |=> status.completionFlag ##1 (conversionEndInterrupt ==
            status.completionIrqEnable || $changed(status.completionIrqEnable));
    endproperty
    a_flagSet: assert property (p_flagSet) else $error("flag or irq missing"); // RULE10

    property p_abort;
        @(posedge clock) disable iff (!arst_n)
        $fell(status.conversionStartBit) |-> state == adc_sequencer_pkg::ST_WAIT && !sampleHold;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not stop"); // RULE12

    property p_reservedZero;
        @(posedge clock) disable iff (!arst_n)
        control.reserved == 2'h0;
    endproperty
    a_reservedZero: assert property (p_reservedZero) else $error("reserved bits set"); // RULE5

    property p_singleTime;
        @(posedge clock) disable iff (!arst_n)
        singleDone |-> busyCount + 10'h001 >= adc_sequencer_pkg::SINGLE_MIN[control.clockSelect]
            && busyCount + 10'h001 <= adc_sequencer_pkg::SINGLE_MAX[control.clockSelect];
    endproperty
    a_singleTime: assert property (p_singleTime) else $error("single time wrong"); // RULE19

    property p_scanTime;
        @(posedge clock) disable iff (!arst_n)
        convDone && scanRepeat |->
            periodCount + 10'h001 == adc_sequencer_pkg::SCAN_TIME[control.clockSelect];
    endproperty
    a_scanTime: assert property (p_scanTime) else $error("scan period wrong"); // RULE20

    sequence s_groupWrap;
        convDone && control.scanEnable && lastChannel && next_startBit;
    endsequence

    property p_scanWrap;
        @(posedge clock) disable iff (!arst_n)
        s_groupWrap |=> status.completionFlag && status.conversionStartBit &&
            state == adc_sequencer_pkg::ST_SAMPLE;
    endproperty
    a_scanWrap: assert property (p_scanWrap) else $error("scan wrap wrong"); // RULE15

    property p_triggerGate;
        @(posedge clock) disable iff (!arst_n)
        $rose(status.conversionStartBit) |->
            $past(swStatusWrite) || $past(control.triggerSource) != adc_sequencer_pkg::TRIG_NONE;
    endproperty
    a_triggerGate: assert property (p_triggerGate) else $error("start without source"); // RULE25

    property p_sampleWindow;
        @(posedge clock) disable iff (!arst_n)
        $rose(sampleHold) && control.clockSelect == 2'h3 |->
            (sampleHold || !status.conversionStartBit) [*8] ##7
            (sampleHold || !status.conversionStartBit) ##1 !sampleHold;
    endproperty
    a_sampleWindow: assert property (p_sampleWindow) else $error("sample window wrong"); // RULE17

    property p_resultStore;
        @(posedge clock) disable iff (!arst_n)
        convDone |=> results[$past(analogChannel)] == $past(dacCode);
    endproperty
    a_resultStore: assert property (p_resultStore) else $error("result not stored"); // RULE14

endmodule

`default_nettype wire

// *** verification/adc_input_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Comparator with one fixed level per input; an ideal part, never late.
module adc_input_model (
    input wire logic [2:0] analogChannel,
    input wire logic [9:0] dacCode,
    output logic compareHigh
);
    assign compareHigh = ({analogChannel, 7'h15} >= dacCode);
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, compareHigh, sampleHold;
    logic [1:0] bresp, rresp;
    logic pulseTimerTrigger = 0, eightBitTimerTrigger = 0, externalTriggerPin_n = 1;
    logic transferRead = 0, conversionEndInterrupt;
    logic [9:0] dacCode;
    logic [2:0] analogChannel;
    int errors = 0, samples_checked = 0, cycles = 0, n;
    adc_conversion_sequencer u_adc_conversion_sequencer (.clock, .arst_n, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pulseTimerTrigger,
        .eightBitTimerTrigger, .externalTriggerPin_n, .transferRead, .compareHigh,
        .sampleHold, .dacCode, .analogChannel, .conversionEndInterrupt);
    adc_input_model u_adc_input_model (.analogChannel, .dacCode, .compareHigh);
    initial
    begin
        forever #2 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            end_of_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic awOpen, wOpen;
        awOpen = 1'b1;
        wOpen = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (awOpen || wOpen)
        begin
            @(posedge clock);
            if (awOpen && awready)
            begin
                awOpen = 1'b0;
                awvalid <= 1'b0;
            end
            if (wOpen && wready)
            begin
                wOpen = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, input logic [31:0] want);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        rd = rdata;
        rready <= 1'b0;
        check(rd, want);
    endtask
    // Counts from its call, after the starting write or trigger, until the request line rises or 2000 cycles pass.
    task automatic wait_irq();
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (!conversionEndInterrupt && n < 2000);
    endtask
    task automatic reset_and_control();
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        rdr(8'h00, 32'h0);
        wr(8'h00, 32'hff);
        rdr(8'h00, 32'hfc);
        wr(8'h00, 32'h0c);
        pulseTimerTrigger <= 1'b1;
        externalTriggerPin_n <= 1'b0;
        @(posedge clock);
        pulseTimerTrigger <= 1'b0;
        eightBitTimerTrigger <= 1'b1;
        @(posedge clock);
        eightBitTimerTrigger <= 1'b0;
        externalTriggerPin_n <= 1'b1;
        repeat (8) @(posedge clock);
        rdr(8'h04, 32'h0);
    endtask
    task automatic single_software();
        wr(8'h04, 32'h65);
        wait_irq();
        check(n >= 66 && n <= 72, 1);
        rdr(8'h24, 32'h295);
        rdr(8'h04, 32'hc5);
        wr(8'h04, 32'h40);
        rdr(8'h04, 32'h40);
    endtask
    task automatic pin_start();
        wr(8'h00, 32'hcc);
        externalTriggerPin_n <= 1'b0;
        wait_irq();
        externalTriggerPin_n <= 1'b1;
        rdr(8'h10, 32'h015);
        rdr(8'h04, 32'hc0);
        wr(8'h04, 32'h40);
    endtask
    task automatic scan_four();
        wr(8'h00, 32'h2c);
        wr(8'h04, 32'h67);
        wait_irq();
        check(n >= 258 && n <= 266, 1);
        rdr(8'h20, 32'h215);
        rdr(8'h2c, 32'h395);
        rdr(8'h04, 32'he7);
        wr(8'h04, 32'h47);
        rdr(8'h04, 32'h47);
    endtask
    // Eight-channel group of two inputs, started by the pulse timer.
    task automatic scan_eight_timer();
        wr(8'h00, 32'h7c);
        wr(8'h04, 32'h41);
        pulseTimerTrigger <= 1'b1;
        @(posedge clock);
        pulseTimerTrigger <= 1'b0;
        wait_irq();
        check(n >= 130 && n <= 136, 1);
        rdr(8'h14, 32'h095);
        transferRead <= 1'b1;
        @(posedge clock);
        transferRead <= 1'b0;
        rdr(8'h04, 32'h61);
        wr(8'h04, 32'h43);
    endtask
    task automatic timer_single();
        wr(8'h00, 32'h8c);
        eightBitTimerTrigger <= 1'b1;
        @(posedge clock);
        eightBitTimerTrigger <= 1'b0;
        wait_irq();
        rdr(8'h1c, 32'h195);
    endtask
    initial
    begin
        reset_and_control();
        single_software();
        pin_start();
        scan_four();
        scan_eight_timer();
        timer_single();
        end_of_test();
    end
endmodule
`default_nettype wire
